// *** design/mdio_bridge_defs.svh ***
`ifndef MDIO_BRIDGE_DEFS_SVH
`define MDIO_BRIDGE_DEFS_SVH
`define PHY_ADDR_LO   5'h00
`define PHY_ADDR_HI   5'h1F
`define PREAMBLE_LEN  6'h20
`define OP_READ       2'h2
`define OP_WRITE      2'h1
`define RG_ADDR_LO    5'h00
`define RG_ADDR_HI    5'h01
`define RG_DATA_LO    5'h02
`define RG_DATA_HI    5'h03
`define RG_DATA_INC   5'h04
`define RG_DATA_PAS   5'h05
`define RG_STATUS     5'h06
`define ERR_HALF      16'h8888
`define ERR_WORD      32'h88888888
`define IND_STEP      32'h00000001
`define WIN_STEP      32'h00000004
`define WIN_CTRL_WA   32'h00004000
`define WIN_ADDR_WA   32'h00004001
`define WIN_DATA_WA   32'h00004002
`define WIN_DINC_WA   32'h00004003
`define WIN_DPAS_WA   32'h00004004
`define WIN_BUSY_BIT  0
`define WIN_FAULT_BIT 1
`endif

// *** design/mdio_bridge_pkg.sv ***
package mdio_bridge_pkg;
    typedef struct packed {
        logic        wr;
        logic [31:0] addr;
        logic [31:0] wdata;
    } xreq_t;
    typedef struct packed {
        logic        err;
        logic [31:0] rdata;
    } xrsp_t;
    typedef enum logic [1:0] {L_IDLE, L_HDR, L_TA, L_DATA} link_st_t;
    typedef enum logic [1:0] {C_IDLE, C_DEC, C_BUS, C_DONE} core_st_t;
endpackage

// *** design/mdio_slave_bridge.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "mdio_bridge_defs.svh"
module mdio_slave_bridge
    import mdio_bridge_pkg::*;
(
    // core clock and reset
    input  wire logic        clk_i,
    input  wire logic        nrst_i,
    // management link
    input  wire logic        mgmt_slave_clock_i,
    input  wire logic        mgmt_slave_data_i,
    output logic             mgmt_slave_data_o,
    output logic             mgmt_slave_data_oe_o,
    input  wire logic        phy_address_select_i,
    // internal register bus
    output logic             csr_req_o,
    output logic             csr_wr_o,
    output logic [31:0]      csr_addr_o,
    output logic [31:0]      csr_wdata_o,
    input  wire logic        csr_ack_i,
    input  wire logic        csr_err_i,
    input  wire logic [31:0] csr_rdata_i,
    // shared system bus
    output logic             sba_req_o,
    output logic             sba_wr_o,
    output logic [31:0]      sba_addr_o,
    output logic [31:0]      sba_wdata_o,
    input  wire logic        sba_ack_i,
    input  wire logic        sba_err_i,
    input  wire logic [31:0] sba_rdata_i
);
    // link domain state
    link_st_t    lst_q;
    logic [4:0]  cnt_q;
    logic [5:0]  ones_q;
    logic [15:0] sr_q;
    logic [15:0] tx_q;
    logic        rd_q;
    logic        wr_q;
    logic [4:0]  regn_q;
    logic        sel_s1_q;
    logic        sel_s2_q;
    logic [15:0] al_q;
    logic [15:0] ah_q;
    logic [15:0] dl_q;
    logic [15:0] dh_q;
    logic        err_q;
    logic        brd_q;
    logic        pend_q;
    logic        rqw_q;
    logic        incr_q;
    logic        req_tg_q;
    logic        ack_s1_q;
    logic        ack_s2_q;
    logic        ack_s3_q;
    // core domain state
    core_st_t    cst_q;
    xreq_t       cap_q;
    xrsp_t       rsp_q;
    logic        ack_tg_q;
    logic        rq_s1_q;
    logic        rq_s2_q;
    logic        rq_s3_q;
    logic [31:0] wa_q;
    logic [31:0] wd_q;
    logic        wfault_q;

    logic [12:0] hdr;
    logic [4:0]  phy_sel;
    logic        hdr_ok;
    logic [15:0] rd_val;
    logic        fr_end;
    logic [15:0] wdat;
    logic        done;
    logic        pend_n;
    logic        launch;
    xreq_t       req;
    logic        start;
    logic        acc;
    logic        win_hit;
    logic [31:0] win_rd;

    assign hdr     = {sr_q[11:0], mgmt_slave_data_i};
    assign phy_sel = sel_s2_q ? `PHY_ADDR_HI : `PHY_ADDR_LO;
    assign hdr_ok  = hdr[12] && (hdr[9:5] == phy_sel) && (hdr[4:0] <= `RG_STATUS)
                     && (hdr[11:10] == `OP_READ || hdr[11:10] == `OP_WRITE);
    assign fr_end  = (lst_q == L_DATA) && (cnt_q == 5'h0F);
    assign wdat    = {sr_q[14:0], mgmt_slave_data_i};
    assign done    = ack_s2_q ^ ack_s3_q;
    assign pend_n  = pend_q & ~done;
    assign launch  = fr_end && !pend_n
                     && (regn_q == `RG_DATA_HI || regn_q == `RG_DATA_INC);
    // address is already a word address
    assign req     = '{wr: rqw_q, addr: {ah_q, al_q}, wdata: {dh_q, dl_q}};

    always_comb begin
        case (hdr[4:0])
            `RG_ADDR_LO: rd_val = al_q;
            `RG_ADDR_HI: rd_val = ah_q;
            `RG_DATA_LO: rd_val = err_q ? `ERR_HALF : dl_q;
            `RG_DATA_HI,
            `RG_DATA_INC: rd_val = (pend_q || err_q) ? `ERR_HALF : dh_q;
            `RG_DATA_PAS: rd_val = err_q ? `ERR_HALF : dh_q;
            `RG_STATUS: rd_val = {13'h0000, err_q, brd_q, pend_q};
            default: rd_val = 16'h0000;
        endcase
    end

    // select pin synchroniser
    always_ff @(posedge mgmt_slave_clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            sel_s1_q <= 1'b0;
            sel_s2_q <= 1'b0;
        end else begin
            sel_s1_q <= phy_address_select_i;
            sel_s2_q <= sel_s1_q;
        end
    end

    // frame engine on rising link edge
    always_ff @(posedge mgmt_slave_clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            lst_q                <= L_IDLE;
            cnt_q                <= 5'h00;
            ones_q               <= 6'h00;
            sr_q                 <= 16'h0000;
            tx_q                 <= 16'h0000;
            rd_q                 <= 1'b0;
            wr_q                 <= 1'b0;
            regn_q               <= 5'h00;
            mgmt_slave_data_o    <= 1'b0;
            mgmt_slave_data_oe_o <= 1'b0;
        end else begin
            case (lst_q)
                L_IDLE: begin
                    cnt_q <= 5'h00;
                    if (mgmt_slave_data_i) begin
                        if (ones_q != `PREAMBLE_LEN)
                            ones_q <= ones_q + 6'h01;
                    end else begin
                        if (ones_q == `PREAMBLE_LEN)
                            lst_q <= L_HDR;
                        ones_q <= 6'h00;
                    end
                end
                L_HDR: begin
                    sr_q  <= wdat;
                    cnt_q <= cnt_q + 5'h01;
                    if (cnt_q == 5'h0C) begin
                        cnt_q  <= 5'h00;
                        lst_q  <= hdr_ok ? L_TA : L_IDLE;
                        rd_q   <= hdr[11:10] == `OP_READ;
                        wr_q   <= hdr[11:10] == `OP_WRITE;
                        regn_q <= hdr[4:0];
                        tx_q   <= rd_val;
                    end
                end
                L_TA: begin
                    if (cnt_q == 5'h00) begin
                        cnt_q <= 5'h01;
                        if (rd_q) begin
                            mgmt_slave_data_oe_o <= 1'b1;
                            mgmt_slave_data_o    <= 1'b0;
                        end
                    end else begin
                        cnt_q <= 5'h00;
                        lst_q <= L_DATA;
                        if (rd_q) begin
                            mgmt_slave_data_o <= tx_q[15];
                            tx_q              <= {tx_q[14:0], 1'b0};
                        end
                    end
                end
                L_DATA: begin
                    sr_q  <= wdat;
                    cnt_q <= cnt_q + 5'h01;
                    if (rd_q) begin
                        mgmt_slave_data_o <= tx_q[15];
                        tx_q              <= {tx_q[14:0], 1'b0};
                    end
                    if (fr_end) begin
                        lst_q                <= L_IDLE;
                        cnt_q                <= 5'h00;
                        rd_q                 <= 1'b0;
                        mgmt_slave_data_o    <= 1'b0;
                        mgmt_slave_data_oe_o <= 1'b0;
                    end
                end
                default: lst_q <= L_IDLE;
            endcase
        end
    end

    // completion toggle synchroniser
    always_ff @(posedge mgmt_slave_clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            ack_s1_q <= 1'b0;
            ack_s2_q <= 1'b0;
            ack_s3_q <= 1'b0;
        end else begin
            ack_s1_q <= ack_tg_q;
            ack_s2_q <= ack_s1_q;
            ack_s3_q <= ack_s2_q;
        end
    end

    // indirect register file; writes held off while an access is pending
    always_ff @(posedge mgmt_slave_clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            al_q     <= 16'h0000;
            ah_q     <= 16'h0000;
            dl_q     <= 16'h0000;
            dh_q     <= 16'h0000;
            err_q    <= 1'b0;
            brd_q    <= 1'b0;
            pend_q   <= 1'b0;
            rqw_q    <= 1'b0;
            incr_q   <= 1'b0;
            req_tg_q <= 1'b0;
        end else begin
            if (done) begin
                pend_q <= 1'b0;
                err_q  <= rsp_q.err;
                // read result kept for next read
                if (!rqw_q && !rsp_q.err)
                    {dh_q, dl_q} <= rsp_q.rdata;
                if (incr_q)
                    {ah_q, al_q} <= {ah_q, al_q} + `IND_STEP;
            end
            if (fr_end && wr_q && !pend_n) begin
                case (regn_q)
                    `RG_ADDR_LO: al_q <= wdat;
                    `RG_ADDR_HI: ah_q <= wdat;
                    `RG_DATA_LO: dl_q <= wdat;
                    `RG_DATA_HI,
                    `RG_DATA_INC,
                    `RG_DATA_PAS: dh_q <= wdat;
                    default: ;
                endcase
            end
            if (fr_end && (regn_q == `RG_DATA_HI || regn_q == `RG_DATA_INC))
                brd_q <= pend_n;
            // launch once the frame is over
            if (launch) begin
                req_tg_q <= ~req_tg_q;
                pend_q   <= 1'b1;
                rqw_q    <= wr_q;
                incr_q   <= regn_q == `RG_DATA_INC;
            end
        end
    end

    // request toggle synchroniser; request fields are stable while pending
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rq_s1_q <= 1'b0;
            rq_s2_q <= 1'b0;
            rq_s3_q <= 1'b0;
        end else begin
            rq_s1_q <= req_tg_q;
            rq_s2_q <= rq_s1_q;
            rq_s3_q <= rq_s2_q;
        end
    end

    assign start   = rq_s2_q ^ rq_s3_q;
    assign acc     = cst_q == C_DEC;
    assign win_hit = cap_q.addr >= `WIN_CTRL_WA && cap_q.addr <= `WIN_DPAS_WA;

    always_comb begin
        case (cap_q.addr)
            `WIN_CTRL_WA: win_rd = {30'h00000000, wfault_q, sba_req_o};
            `WIN_ADDR_WA: win_rd = wa_q;
            `WIN_DATA_WA,
            `WIN_DINC_WA,
            `WIN_DPAS_WA: win_rd = sba_req_o ? `ERR_WORD : wd_q;
            default: win_rd = 32'h00000000;
        endcase
    end

    // core access engine
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            cst_q       <= C_IDLE;
            cap_q       <= '0;
            rsp_q       <= '0;
            ack_tg_q    <= 1'b0;
            csr_req_o   <= 1'b0;
            csr_wr_o    <= 1'b0;
            csr_addr_o  <= 32'h00000000;
            csr_wdata_o <= 32'h00000000;
        end else begin
            case (cst_q)
                C_IDLE: begin
                    if (start) begin
                        cap_q <= req;
                        cst_q <= C_DEC;
                    end
                end
                C_DEC: begin
                    if (win_hit) begin
                        rsp_q <= '{err: 1'b0, rdata: win_rd};
                        cst_q <= C_DONE;
                    end else begin
                        csr_req_o   <= 1'b1;
                        csr_wr_o    <= cap_q.wr;
                        csr_addr_o  <= cap_q.addr;
                        csr_wdata_o <= cap_q.wdata;
                        cst_q       <= C_BUS;
                    end
                end
                C_BUS: begin
                    if (csr_ack_i) begin
                        csr_req_o <= 1'b0;
                        rsp_q     <= '{err: csr_err_i, rdata: csr_rdata_i};
                        cst_q     <= C_DONE;
                    end
                end
                C_DONE: begin
                    ack_tg_q <= ~ack_tg_q;
                    cst_q    <= C_IDLE;
                end
                default: cst_q <= C_IDLE;
            endcase
        end
    end

    // shared bus window; accesses arriving while busy are dropped
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            wa_q        <= 32'h00000000;
            wd_q        <= 32'h00000000;
            wfault_q    <= 1'b0;
            sba_req_o   <= 1'b0;
            sba_wr_o    <= 1'b0;
            sba_addr_o  <= 32'h00000000;
            sba_wdata_o <= 32'h00000000;
        end else if (sba_req_o) begin
            if (sba_ack_i) begin
                sba_req_o <= 1'b0;
                if (sba_err_i) begin
                    wfault_q <= 1'b1;
                    wd_q     <= `ERR_WORD;
                end else if (!sba_wr_o) begin
                    wd_q <= sba_rdata_i;
                end
            end
        end else if (acc && win_hit) begin
            case (cap_q.addr)
                `WIN_CTRL_WA: begin
                    if (cap_q.wr && cap_q.wdata[`WIN_FAULT_BIT])
                        wfault_q <= 1'b0;
                end
                `WIN_ADDR_WA: begin
                    if (cap_q.wr)
                        wa_q <= cap_q.wdata;
                end
                `WIN_DATA_WA,
                `WIN_DINC_WA: begin
                    if (cap_q.wr)
                        wd_q <= cap_q.wdata;
                    sba_req_o   <= 1'b1;
                    sba_wr_o    <= cap_q.wr;
                    sba_addr_o  <= wa_q;
                    sba_wdata_o <= cap_q.wr ? cap_q.wdata : wd_q;
                    if (cap_q.addr == `WIN_DINC_WA)
                        wa_q <= wa_q + `WIN_STEP;
                end
                `WIN_DPAS_WA: begin
                    if (cap_q.wr)
                        wd_q <= cap_q.wdata;
                end
                default: ;
            endcase
        end
    end

    chk_drive_read_only: assert property (
        @(posedge mgmt_slave_clock_i) disable iff (!nrst_i)
        mgmt_slave_data_oe_o |-> rd_q && (lst_q == L_TA || lst_q == L_DATA))
        else $error("data line driven outside read data");
    chk_turnaround_zero: assert property (
        @(posedge mgmt_slave_clock_i) disable iff (!nrst_i)
        $rose(mgmt_slave_data_oe_o) |-> !mgmt_slave_data_o ##1 mgmt_slave_data_oe_o [*8])
        else $error("turnaround bit wrong or drive too short");
    chk_launch_sets_pend: assert property (
        @(posedge mgmt_slave_clock_i) disable iff (!nrst_i)
        launch |=> pend_q && $changed(req_tg_q))
        else $error("launch did not mark pending");
    chk_incr_address: assert property (
        @(posedge mgmt_slave_clock_i) disable iff (!nrst_i)
        done && incr_q |=> {ah_q, al_q} == $past({ah_q, al_q}) + `IND_STEP)
        else $error("indirect address not incremented");
    chk_busy_half_marker: assert property (
        @(posedge mgmt_slave_clock_i) disable iff (!nrst_i)
        lst_q == L_HDR && cnt_q == 5'h0C && hdr[4:0] == `RG_DATA_HI && pend_q
        |=> tx_q == `ERR_HALF)
        else $error("busy upper half read not marked");
    chk_win_busy_data: assert property (
        @(posedge clk_i) disable iff (!nrst_i)
        acc && sba_req_o && cap_q.addr == `WIN_DATA_WA |=> rsp_q.rdata == `ERR_WORD)
        else $error("window data read while busy not marked");
    chk_win_incr_step: assert property (
        @(posedge clk_i) disable iff (!nrst_i)
        acc && !sba_req_o && cap_q.addr == `WIN_DINC_WA |=> wa_q == $past(wa_q) + `WIN_STEP && sba_req_o)
        else $error("window address not stepped by four");
    chk_win_fault: assert property (
        @(posedge clk_i) disable iff (!nrst_i)
        sba_req_o && sba_ack_i && sba_err_i |=> wfault_q && wd_q == `ERR_WORD && !sba_req_o)
        else $error("bus error not reported");
    chk_win_write_start: assert property (
        @(posedge clk_i) disable iff (!nrst_i)
        acc && !sba_req_o && cap_q.wr && cap_q.addr == `WIN_DATA_WA
        |=> sba_req_o && sba_wr_o && sba_wdata_o == $past(cap_q.wdata))
        else $error("window write did not start bus write");
endmodule // mdio_slave_bridge
`default_nettype wire

// *** tb/bus_responder.sv ***
`timescale 1ns/1ps
`default_nettype none
module bus_responder (
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        nrst_i,
    // behaviour control
    input  wire logic [15:0] lat_i,
    input  wire logic        fail_i,
    // request side
    input  wire logic        req_i,
    input  wire logic [31:0] addr_i,
    output logic             ack_o,
    output logic             err_o,
    output logic [31:0]      rdata_o
);
    logic [15:0] cnt_q;

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            cnt_q   <= 16'h0000;
            ack_o   <= 1'b0;
            err_o   <= 1'b0;
            rdata_o <= 32'h0000_0000;
        end else if (req_i && !ack_o && cnt_q >= lat_i) begin
            cnt_q   <= 16'h0000;
            ack_o   <= 1'b1;
            err_o   <= fail_i;
            rdata_o <= {addr_i[15:0] ^ 16'hA55A, ~addr_i[15:0]};
        end else begin
            cnt_q   <= (req_i && !ack_o) ? cnt_q + 16'h0001 : 16'h0000;
            ack_o   <= 1'b0;
            // outside the ack cycle nothing is valid, so invert the held values every cycle
            err_o   <= ~err_o;
            rdata_o <= ~rdata_o;
        end
    end
endmodule // bus_responder
`default_nettype wire

// *** tb/test_mdio_slave_bridge.sv ***
`timescale 1ns/1ps
`default_nettype none
module test_mdio_slave_bridge;
    import mdio_bridge_pkg::*;
    logic        clk_i = 1'b0;
    logic        nrst_i = 1'b0;
    logic        mdc = 1'b0;
    logic        m_oe = 1'b0;
    logic        m_d = 1'b1;
    logic        sel = 1'b0;
    logic        fail_c = 1'b0;
    logic        fail_s = 1'b0;
    logic [4:0]  phy = 5'h00;
    logic [15:0] lat_c = 16'h0002;
    logic [15:0] lat_s = 16'h0002;
    logic [15:0] got;
    logic        dout, oe, creq, cwr, cack, cerr, sreq, swr, sack, serr;
    logic [31:0] caddr, cwd, crd, saddr, swd, srd;
    logic [31:0] rq[$];
    xreq_t       cq[$];
    xreq_t       sq[$];
    int          num_errors = 0;
    int          compares = 0;
    event        rd_ev;
    // released line floats up through the pull-up
    wire logic   line = oe ? dout : (m_oe ? m_d : 1'b1);

    mdio_slave_bridge uut (
        .clk_i(clk_i), .nrst_i(nrst_i), .mgmt_slave_clock_i(mdc), .mgmt_slave_data_i(line),
        .mgmt_slave_data_o(dout), .mgmt_slave_data_oe_o(oe), .phy_address_select_i(sel),
        .csr_req_o(creq), .csr_wr_o(cwr), .csr_addr_o(caddr), .csr_wdata_o(cwd),
        .csr_ack_i(cack), .csr_err_i(cerr), .csr_rdata_i(crd),
        .sba_req_o(sreq), .sba_wr_o(swr), .sba_addr_o(saddr), .sba_wdata_o(swd),
        .sba_ack_i(sack), .sba_err_i(serr), .sba_rdata_i(srd)
    );
    bus_responder csr_end (.clk_i(clk_i), .nrst_i(nrst_i), .lat_i(lat_c), .fail_i(fail_c), .req_i(creq),
        .addr_i(caddr), .ack_o(cack), .err_o(cerr), .rdata_o(crd));
    bus_responder sba_end (.clk_i(clk_i), .nrst_i(nrst_i), .lat_i(lat_s), .fail_i(fail_s), .req_i(sreq),
        .addr_i(saddr), .ack_o(sack), .err_o(serr), .rdata_o(srd));

    always #10 clk_i = ~clk_i;

    task automatic chk(input logic [64:0] g, input logic [64:0] e);
        compares++;
        if (g !== e) begin
            num_errors++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, g, e);
        end
    endtask

    task automatic give_verdict();
        if (cq.size() + sq.size() + rq.size() != 0) num_errors++;
        $display("comparisons %0d mismatches %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    function automatic logic [31:0] f(input logic [31:0] a);
        return {a[15:0] ^ 16'hA55A, ~a[15:0]};
    endfunction

    // one whole frame; outside reset the link clock only runs inside frames
    task automatic fr(input logic [1:0] op, input logic [4:0] ra, input logic [15:0] d);
        logic [63:0] v;
        logic        rdf;
        v = {32'hFFFF_FFFF, 2'b01, op, phy, ra, 2'b10, d};
        rdf = op == 2'b10 && phy == (sel ? 5'h1F : 5'h00);
        for (int i = 63; i >= 0; i--) begin
            m_oe = op == 2'b01 || i > 17;
            m_d = v[i];
            #40;
            chk(65'(oe), 65'(rdf && i < 17));
            got[i % 16] = line;
            mdc = 1'b1;
            #40;
            mdc = 1'b0;
        end
        m_oe = 1'b0;
        if (rdf) -> rd_ev;
    endtask

    task automatic wr(input logic [4:0] ra, input logic [15:0] d);
        fr(2'b01, ra, d);
    endtask

    task automatic rd(input logic [4:0] ra, input logic [15:0] e, input logic [15:0] m = 16'hFFFF);
        rq.push_back({m, e});
        fr(2'b10, ra, 16'h0000);
    endtask

    task automatic sa(input logic [31:0] a);
        wr(5'h00, a[15:0]);
        wr(5'h01, a[31:16]);
    endtask

    task automatic ld(input logic [31:0] a, input logic [31:0] d, input logic [4:0] ra);
        wr(5'h02, d[15:0]);
        if (a > 32'h0000_4004) cq.push_back({1'b1, a, d});
        wr(ra, d[31:16]);
    endtask

    always @(posedge clk_i) begin
        if (creq && cack) chk({cwr, caddr, cwr ? cwd : 32'h0}, cq.pop_front());
        if (sreq && sack) chk({swr, saddr, swr ? swd : 32'h0}, sq.pop_front());
    end

    always @(rd_ev) begin
        chk(65'(got & rq[0][31:16]), 65'(rq[0][15:0] & rq[0][31:16]));
        void'(rq.pop_front());
    end

    initial begin
        #1000000;
        num_errors++;
        give_verdict();
    end

    initial begin
        logic [31:0] a, d, w, e;
        void'($urandom(32'h10A5127F));
        // a few link edges inside reset; the link-side synchronisers stay held at zero until nrst_i rises
        for (int k = 0; k < 4; k++) begin
            #40 mdc = 1'b1;
            #40 mdc = 1'b0;
        end
        nrst_i = 1'b1;
        phy = 5'h1F;
        wr(5'h00, 16'hFFFF);
        fr(2'b10, 5'h00, 16'h0000);
        phy = 5'h00;
        rd(5'h00, 16'h0000);
        $display("test address select done");
        e = $urandom | 32'h0010_0000;
        a = (e & 32'h00FF_FFFF) >> 2;
        d = $urandom;
        sa(a);
        ld(a, d, 5'h03);
        rd(5'h02, d[15:0]);
        cq.push_back({1'b0, a, 32'h0});
        rd(5'h03, d[31:16]);
        e = f(a);
        rd(5'h02, e[15:0]);
        rd(5'h05, e[31:16]);
        d = $urandom;
        ld(a, d, 5'h04);
        d = $urandom;
        ld(a + 32'h1, d, 5'h03);
        rd(5'h00, a[15:0] + 16'h0001);
        $display("test indirect access done");
        lat_c = 16'h0258;
        cq.push_back({1'b0, a + 32'h1, 32'h0});
        rd(5'h03, d[31:16]);
        rd(5'h03, 16'h8888);
        rd(5'h06, 16'h0001, 16'h0005);
        rd(5'h00, a[15:0] + 16'h0001);
        e = f(a + 32'h1);
        rd(5'h05, e[31:16]);
        rd(5'h06, 16'h0000, 16'h0005);
        $display("test busy status done");
        lat_c = 16'h0002;
        fail_c = 1'b1;
        cq.push_back({1'b0, a + 32'h1, 32'h0});
        rd(5'h03, e[31:16]);
        rd(5'h02, 16'h8888);
        rd(5'h05, 16'h8888);
        rd(5'h06, 16'h0004, 16'h0005);
        fail_c = 1'b0;
        $display("test internal error done");
        sel = 1'b1;
        fr(2'b10, 5'h00, 16'h0000);
        phy = 5'h1F;
        w = $urandom & 32'hFFFF_FFFC;
        d = $urandom;
        sa(32'h0000_4001);
        ld(32'h0000_4001, w, 5'h03);
        wr(5'h00, 16'h4002);
        sq.push_back({1'b1, w, d});
        ld(32'h0000_4002, d, 5'h03);
        d = $urandom;
        wr(5'h00, 16'h4003);
        sq.push_back({1'b1, w, d});
        ld(32'h0000_4003, d, 5'h03);
        sq.push_back({1'b0, w + 32'h4, 32'h0});
        rd(5'h03, d[31:16]);
        sq.push_back({1'b0, w + 32'h8, 32'h0});
        rd(5'h03, d[31:16]);
        e = f(w + 32'h4);
        rd(5'h02, e[15:0]);
        wr(5'h00, 16'h4004);
        rd(5'h03, e[31:16]);
        e = f(w + 32'h8);
        rd(5'h02, e[15:0]);
        rd(5'h05, e[31:16]);
        lat_s = 16'h0320;
        wr(5'h00, 16'h4003);
        sq.push_back({1'b0, w + 32'hC, 32'h0});
        rd(5'h03, e[31:16]);
        rd(5'h03, e[31:16]);
        rd(5'h02, 16'h8888);
        lat_s = 16'h0002;
        wr(5'h00, 16'h4004);
        rd(5'h03, 16'h8888);
        e = f(w + 32'hC);
        rd(5'h02, e[15:0]);
        wr(5'h00, 16'h4001);
        rd(5'h03, e[31:16]);
        e = w + 32'h10;
        rd(5'h02, e[15:0]);
        rd(5'h05, e[31:16]);
        fail_s = 1'b1;
        wr(5'h00, 16'h4002);
        sq.push_back({1'b1, w + 32'h10, d});
        ld(32'h0000_4002, d, 5'h03);
        wr(5'h00, 16'h4004);
        rd(5'h03, d[31:16]);
        rd(5'h02, 16'h8888);
        wr(5'h00, 16'h4000);
        rd(5'h03, 16'h8888);
        rd(5'h02, 16'h0002, 16'h0003);
        fail_s = 1'b0;
        $display("test window access done");
        // let the last read check run before the queues are audited
        #200;
        give_verdict();
    end
endmodule // test_mdio_slave_bridge
`default_nettype wire
